/* File: core/msp_pkg.sv */
package msp_pkg;
  // Clocking of the block and of the measurement path
  localparam int CLK_HZ = 100_000_000;
  localparam int MEAS_HZ = 4_000_000;
  localparam int MEAS_DIV = CLK_HZ / MEAS_HZ;
  localparam int LATCH_PERIODS = 2;
  localparam int RESTART_MS = 125;
  localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
  // Records and commands
  localparam int REC_BITS = 32;
  localparam int MAX_RECS = 8;
  localparam int CFG_BITS = 112;
  localparam int MODE_BITS = 15;
  localparam logic [6:0] ADDR_MODE_BASE = 7'h70;
  localparam logic [6:0] ADDR_PRECHARGE = 7'h7F;
  localparam logic [2:0] CMD_LAST_BIT = 3'h7;
  localparam int MSB_FIRST_CFG_IDX = 100;
  localparam int CLOCK_POLARITY_CFG_IDX = 101;
  // Register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_CFG0 = 8'h0C;
  localparam int CFG_WORDS = 4;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int ST_CNT_LSB = 3;
  localparam int ST_WR_BIT = 12;
  localparam int ST_RD_BIT = 13;
  localparam int ST_READY_BIT = 14;

  typedef struct packed {
    logic selN;
    logic sync;
    logic sclk;
    logic sdata;
  } msp_pins_s;
endpackage

/* File: core/msp_port.sv */
`timescale 1ns/1ps
// Overview of operation
// [R1] Remote reset skips long power-on restart
// [R2] Remote reset keeps mode bits unchanged
// [R3] Host holds remote reset over 30 ns
// [R4] Host spaces control pin edges over 30 ns; end_shift raises select with the last read clock edge
// [R5] Idle-select sync pulse latches all records
// [R6] Sync pulse after select clears bit counter
// [R7] 32 clocks per record, eight records maximum
// [R8] Select release aborts any task at once
// [R9] Record sent low byte first, parity top
// [R10] Bytes msb first unless lsb option set
// [R11] Precharge command advances the group pointer
// [R12] Host rechecks records, repeats shifting only
// [R13] Every writable bit has seven-bit address
// [R14] Command byte: data bit then address
// [R15] Config below 0x70, mode bits above
// [R16] Last command clock makes the write strobe
// [R17] Sync low in select makes data input
// [R18] Host raises sync and pulses before reading
// [R19] Host write clock period over 10 us
// [R20] Host may precharge with data held high
// [R21] Sync high reads, sync low writes
// [R22] Data changes trailing, stable leading edge
// [R23] Idle is all four pins high
module msp_port #(
  parameter int NREC = msp_pkg::MAX_RECS,
  parameter int RESTART_CYC = msp_pkg::RESTART_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial port pins
  input wire logic serial_select_n,
  input wire logic sync_direction_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // Measurement datapath side
  input wire logic [NREC*msp_pkg::REC_BITS-1:0] recordsIn,
  output logic latchStrobe,
  output logic remote_reset_pulse,
  output logic digitalReady,
  output logic [$clog2(NREC)-1:0] groupPtr,
  output logic [msp_pkg::CFG_BITS-1:0] cfgBits,
  output logic [msp_pkg::MODE_BITS-1:0] modeBits
);
  localparam int PW = $clog2(NREC);
  localparam int RW = $clog2(RESTART_CYC + 1);

  msp_pkg::msp_pins_s pinRaw, pinMeta_reg, pinSync_reg, pinPrev_reg;
  logic idleLvl, sclkIdle, lead, selAct, selFall, syncFall;
  logic readMode, writeMode, rrrAct, rrrStart, exec, cntClr;
  logic latchAct, measTick, latchNow, selBit;
  logic [7:0] cmd;
  logic [PW-1:0] recIdx;
  logic [2:0] bitIdx;
  logic [31:0] curRec;

  logic [8:0] cnt_reg, cnt_next;
  logic [6:0] sh_reg, sh_next;
  logic outBit_reg, outBit_next;
  logic [msp_pkg::CFG_BITS-1:0] cfg_reg, cfg_next;
  logic [msp_pkg::MODE_BITS-1:0] mode_reg, mode_next;
  logic [PW-1:0] grp_reg, grp_next;
  logic [31:0] latch_reg [NREC];
  logic [31:0] latch_next [NREC];
  logic [4:0] meas_reg, meas_next;
  logic [1:0] pulse_reg, pulse_next;
  logic latchStb_reg, latchStb_next;
  logic rrr_reg, rrr_next, rrrPulse_reg, rrrPulse_next;
  logic [RW-1:0] restart_reg, restart_next;
  logic ready_reg, ready_next;
  logic [1:0] oeHist_reg, oeHist_next;
  logic en_reg, en_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;

  // Pins are asynchronous to clock: two stages before use
  assign pinRaw = '{selN: serial_select_n, sync: sync_direction_pin,
                    sclk: serial_clock_pin, sdata: serial_data_pin_in};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_reg <= '1;
      pinSync_reg <= '1;
      pinPrev_reg <= '1;
    end else begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  // Pin decoding
  always_comb begin
    idleLvl = ~cfg_reg[msp_pkg::CLOCK_POLARITY_CFG_IDX]; // R22
    sclkIdle = (pinSync_reg.sclk == idleLvl);
    lead = (pinPrev_reg.sclk == idleLvl) && !sclkIdle; // R22
    selAct = ~pinSync_reg.selN & en_reg; // R8
    selFall = pinPrev_reg.selN & ~pinSync_reg.selN;
    syncFall = pinPrev_reg.sync & ~pinSync_reg.sync;
    readMode = selAct & pinSync_reg.sync; // R21
    writeMode = selAct & ~pinSync_reg.sync; // R21
    // Data low under an otherwise idle port is the reset request.
    // Our own last read bit still sits in the data synchroniser for two
    // cycles after select rises, so it is masked out here.
    rrrAct = pinSync_reg.selN & pinSync_reg.sync & pinSync_reg.sclk
             & ~pinSync_reg.sdata & (oeHist_reg == 2'h0); // R23
    rrrStart = rrrAct & ~rrr_reg;
    cntClr = selFall | (syncFall & ~pinSync_reg.selN); // R6
    cmd = {sh_reg, pinSync_reg.sdata}; // R14
    exec = writeMode & lead & (cnt_reg[2:0] == msp_pkg::CMD_LAST_BIT)
           & ~cntClr; // R16
    latchAct = pinSync_reg.selN & ~pinSync_reg.sync; // R5
    measTick = (meas_reg == 5'(msp_pkg::MEAS_DIV - 1));
    latchNow = latchAct & measTick
               & (pulse_reg == 2'(msp_pkg::LATCH_PERIODS - 1)); // R5
  end

  // Readout bit selection
  always_comb begin
    recIdx = PW'(cnt_reg[7:5]) + grp_reg; // R11
    // Option set means least significant bit first
    bitIdx = cfg_reg[msp_pkg::MSB_FIRST_CFG_IDX] ? cnt_reg[2:0]
             : ~cnt_reg[2:0]; // R10
    curRec = latch_reg[recIdx];
    selBit = curRec[{cnt_reg[4:3], bitIdx}]; // R9
  end

  // Shift engine
  always_comb begin
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    outBit_next = outBit_reg;
    if (!selAct || cntClr || rrrAct) begin
      cnt_next = '0; // R8
    end else if (lead && (writeMode || !cnt_reg[8])) begin
      // Reading stops after eight records; writing wraps freely
      cnt_next = cnt_reg + 9'h001; // R7
      if (writeMode) begin
        sh_next = cmd[6:0];
      end
    end
    // In read mode the output only moves while the clock rests at its idle level
    if (readMode && sclkIdle) begin
      outBit_next = cnt_reg[8] ? 1'b1 : selBit; // R22
    end else if (!selAct) begin
      outBit_next = 1'b1;
    end
  end

  // Configuration, mode and group pointer
  always_comb begin
    cfg_next = cfg_reg;
    mode_next = mode_reg; // R2
    grp_next = grp_reg;
    if (rrrAct) begin
      cfg_next = '0; // R1
      grp_next = '0;
    end else if (exec) begin
      if (cmd[6:0] == msp_pkg::ADDR_PRECHARGE) begin
        grp_next = grp_reg + PW'(1); // R11
      end else if (cmd[6:0] < msp_pkg::ADDR_MODE_BASE) begin
        cfg_next[cmd[6:0]] = cmd[7]; // R13 R15
      end else begin
        mode_next[cmd[3:0]] = cmd[7]; // R15
      end
    end
  end

  // Transmission latches fed by measurement clock ticks
  always_comb begin
    meas_next = measTick ? 5'h00 : meas_reg + 5'h01;
    pulse_next = pulse_reg;
    latchStb_next = latchNow;
    latch_next = latch_reg;
    if (!latchAct) begin
      pulse_next = '0;
    end else if (measTick && pulse_reg != 2'(msp_pkg::LATCH_PERIODS)) begin
      pulse_next = pulse_reg + 2'h1;
    end
    if (rrrAct) begin
      for (int i = 0; i < NREC; i++) begin
        latch_next[i] = '0;
      end
    end else if (latchNow) begin
      for (int i = 0; i < NREC; i++) begin
        latch_next[i] = recordsIn[i*msp_pkg::REC_BITS +: 32]; // R5
      end
    end
  end

  // Restart delay is owed to power-on only
  always_comb begin
    rrr_next = rrrAct;
    rrrPulse_next = rrrStart;
    oeHist_next = {oeHist_reg[0], readMode};
    restart_next = restart_reg;
    ready_next = ready_reg;
    if (!ready_reg) begin
      if (restart_reg == RW'(RESTART_CYC - 1)) begin
        ready_next = 1'b1;
      end else begin
        restart_next = restart_reg + RW'(1);
      end
    end
  end

  // APB register file
  function automatic logic [32:0] regRead(input logic [7:0] a);
    logic [127:0] cfgWide;
    cfgWide = 128'(cfg_reg);
    regRead = {1'b1, 32'h0000_0000};
    case (a)
      msp_pkg::OFS_CTRL: regRead[0] = en_reg;
      msp_pkg::OFS_STATUS: begin
        regRead[PW-1:0] = grp_reg;
        regRead[msp_pkg::ST_CNT_LSB +: 9] = cnt_reg;
        regRead[msp_pkg::ST_WR_BIT] = writeMode;
        regRead[msp_pkg::ST_RD_BIT] = readMode;
        regRead[msp_pkg::ST_READY_BIT] = ready_reg;
      end
      msp_pkg::OFS_MODE: regRead[msp_pkg::MODE_BITS-1:0] = mode_reg;
      default: begin
        regRead[32] = 1'b0;
        for (int w = 0; w < msp_pkg::CFG_WORDS; w++) begin
          if (a == msp_pkg::OFS_CFG0 + 8'(4 * w)) begin
            regRead = {1'b1, cfgWide[w*32 +: 32]};
          end
        end
      end
    endcase
  endfunction

  always_comb begin
    logic [32:0] rd;
    rd = regRead(paddr);
    rdata_next = rdata_reg;
    err_next = err_reg;
    en_next = en_reg;
    // Answer is prepared in the setup cycle, so no wait states
    if (psel && !penable) begin
      rdata_next = pwrite ? 32'h0000_0000 : rd[31:0];
      err_next = ~rd[32] | (pwrite && paddr != msp_pkg::OFS_CTRL);
    end
    if (psel && penable && pwrite && paddr == msp_pkg::OFS_CTRL) begin
      en_next = pwdata[msp_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      sh_reg <= '0;
      outBit_reg <= 1'b1;
      cfg_reg <= '0;
      mode_reg <= '0;
      grp_reg <= '0;
      for (int i = 0; i < NREC; i++) begin
        latch_reg[i] <= '0;
      end
      meas_reg <= '0;
      pulse_reg <= '0;
      latchStb_reg <= 1'b0;
      rrr_reg <= 1'b0;
      rrrPulse_reg <= 1'b0;
      oeHist_reg <= '0;
      restart_reg <= '0;
      ready_reg <= 1'b0;
      en_reg <= msp_pkg::CTRL_EN_RESET;
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      outBit_reg <= outBit_next;
      cfg_reg <= cfg_next;
      mode_reg <= mode_next;
      grp_reg <= grp_next;
      latch_reg <= latch_next;
      meas_reg <= meas_next;
      pulse_reg <= pulse_next;
      latchStb_reg <= latchStb_next;
      rrr_reg <= rrr_next;
      rrrPulse_reg <= rrrPulse_next;
      oeHist_reg <= oeHist_next;
      restart_reg <= restart_next;
      ready_reg <= ready_next;
      en_reg <= en_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = 1'b1;
  assign pslverr = err_reg;
  assign serial_data_pin_out = outBit_reg;
  assign serial_data_pin_oe = readMode; // R17
  assign latchStrobe = latchStb_reg;
  assign remote_reset_pulse = rrrPulse_reg;
  assign digitalReady = ready_reg;
  assign groupPtr = grp_reg;
  assign cfgBits = cfg_reg;
  assign modeBits = mode_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_rrr_keeps_ready;
    rrrAct && ready_reg |=> ready_reg;
  endproperty
  a_rrr_keeps_ready: assert property (p_rrr_keeps_ready) // R1
    else $error("remote reset dropped ready");

  property p_rrr_keeps_mode;
    rrrAct |=> mode_reg == $past(mode_reg);
  endproperty
  a_rrr_keeps_mode: assert property (p_rrr_keeps_mode) // R2
    else $error("remote reset changed mode bits");

  property p_latch_idle;
    latchNow |-> pinSync_reg.selN ##1 latchStrobe;
  endproperty
  a_latch_idle: assert property (p_latch_idle) // R5
    else $error("latch strobe without idle select");

  property p_clr;
    selFall && en_reg |=> cnt_reg == 9'h000;
  endproperty
  a_clr: assert property (p_clr) // R6
    else $error("counter not cleared at select");

  property p_max_bits;
    cnt_reg[8] && readMode |-> cnt_reg[7:0] == 8'h00;
  endproperty
  a_max_bits: assert property (p_max_bits) // R7
    else $error("read counter ran past eight records");

  property p_abort;
    pinSync_reg.selN |-> !serial_data_pin_oe ##1 cnt_reg == 9'h000;
  endproperty
  a_abort: assert property (p_abort) // R8
    else $error("task not aborted on select release");

  property p_precharge;
    exec && !rrrAct && cmd[6:0] == msp_pkg::ADDR_PRECHARGE
      |=> grp_reg == $past(grp_reg) + PW'(1);
  endproperty
  a_precharge: assert property (p_precharge) // R11
    else $error("precharge did not advance group");

  property p_cfg_write;
    exec && !rrrAct && cmd[6:0] < msp_pkg::ADDR_MODE_BASE
      |=> cfg_reg[$past(cmd[6:0])] == $past(cmd[7]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) // R13
    else $error("configuration bit not written");

  property p_write_input;
    writeMode |-> !serial_data_pin_oe;
  endproperty
  a_write_input: assert property (p_write_input) // R17
    else $error("data driven during write mode");

  property p_out_stable;
    readMode && !sclkIdle ##1 readMode && !sclkIdle
      |-> $stable(serial_data_pin_out);
  endproperty
  a_out_stable: assert property (p_out_stable) // R22
    else $error("data moved while clock active");
endmodule

/* File: sim/msp_host.sv */
`timescale 1ns/1ps
module msp_host #(
  parameter int HALF_RD = 8,
  parameter int HALF_WR = 510
) (
  // Clock
  input wire logic clock,
  // Port pins
  output logic selN,
  output logic syncPin,
  output logic sclkPin,
  output logic hostData,
  output logic hostOe,
  input wire logic dataWire
);
  // Idle is all pins high, data released to its pull-up
  initial {selN, syncPin, sclkPin, hostData, hostOe} <= 5'h1E;
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Gaps of five cycles keep every control pin interval above 30 ns except select rising in end_shift after read_rec
  task automatic begin_shift(input bit doLatch);
    if (doLatch) begin
      syncPin <= 1'b0;
      step(60);
    end
    selN <= 1'b0;
    step(5);
    syncPin <= 1'b0;
    step(5);
    syncPin <= 1'b1;
    step(5);
  endtask
  task automatic end_shift();
    selN <= 1'b1;
    step(5);
  endtask
  // Data sampled just before the leading edge, where it must be stable
  task automatic read_rec(input bit lsbF, output logic [31:0] v);
    for (int i = 0; i < 32; i++) begin
      step(HALF_RD);
      v[i / 8 * 8 + (lsbF ? i % 8 : 7 - i % 8)] = dataWire;
      sclkPin <= 1'b0;
      step(HALF_RD);
      sclkPin <= 1'b1;
    end
  endtask
  task automatic write_cmd(input logic [7:0] cmd);
    syncPin <= 1'b0;
    step(5);
    selN <= 1'b0;
    hostOe <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      hostData <= cmd[i];
      step(HALF_WR);
      sclkPin <= 1'b0;
      step(HALF_WR);
      sclkPin <= 1'b1;
    end
    step(5);
    selN <= 1'b1;
    step(5);
    syncPin <= 1'b1;
    hostOe <= 1'b0;
    hostData <= 1'b1;
    step(5);
  endtask
  // Precharge with the data line left to its pull-up: latch, select,
  // eight clocks, then sync released
  task automatic precharge_plain();
    syncPin <= 1'b0;
    step(120);
    selN <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      step(HALF_WR);
      sclkPin <= 1'b0;
      step(HALF_WR);
      sclkPin <= 1'b1;
    end
    step(5);
    syncPin <= 1'b1;
    step(5);
  endtask
  task automatic remote_reset();
    hostOe <= 1'b1;
    hostData <= 1'b0;
    step(10);
    hostOe <= 1'b0;
    hostData <= 1'b1;
    step(10);
  endtask
endmodule

/* File: sim/msp_port_tb.sv */
`timescale 1ns/1ps
module msp_port_tb;
  localparam int NREC = 8;
  localparam int RCYC = 20;
  logic clock = 1'b0;
  logic arst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, selN, syncPin, sclkPin, hostData, hostOe;
  logic devOut, devOe, latchStrobe, rrPulse, digitalReady;
  logic [NREC*32-1:0] recordsIn;
  logic [2:0] groupPtr;
  logic [111:0] cfgBits;
  logic [14:0] modeBits;
  int fails = 0;
  int samples_checked = 0;
  int latches = 0;
  int resets = 0;
  int clash = 0;
  // Pull-up holds the data line wherever nobody drives it
  wire dataWire = devOe ? devOut : (hostOe ? hostData : 1'b1);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (latchStrobe === 1'b1) latches++;
    if (rrPulse === 1'b1) resets++;
    if (hostOe && devOe !== 1'b0) clash++;
  end
  msp_port #(.NREC(NREC), .RESTART_CYC(RCYC)) msp_port_i (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_select_n(selN),
    .sync_direction_pin(syncPin), .serial_clock_pin(sclkPin),
    .serial_data_pin_in(dataWire), .serial_data_pin_out(devOut),
    .serial_data_pin_oe(devOe), .recordsIn(recordsIn),
    .latchStrobe(latchStrobe), .remote_reset_pulse(rrPulse),
    .digitalReady(digitalReady), .groupPtr(groupPtr),
    .cfgBits(cfgBits), .modeBits(modeBits));
  msp_host msp_host_i (.clock(clock), .selN(selN), .syncPin(syncPin),
    .sclkPin(sclkPin), .hostData(hostData), .hostOe(hostOe),
    .dataWire(dataWire));
  function automatic logic [31:0] rec(input int i);
    return 32'h1357_9BDF + 32'h1111_1111 * i[31:0];
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so two calls never assign psel in one time step
    @(posedge clock);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    print_verdict();
  end
  initial begin
    logic [31:0] v;
    logic e;
    arst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    for (int i = 0; i < NREC; i++) recordsIn[32*i+:32] <= rec(i);
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    check("ready_early", digitalReady, 0);
    apb(1'b0, msp_pkg::OFS_CTRL, 32'h0, v, e);
    check("ctrl", v, 32'h1);
    apb(1'b1, msp_pkg::OFS_STATUS, 32'h1, v, e);
    check("ro_err", e, 1);
    apb(1'b0, 8'h40, 32'h0, v, e);
    check("unmapped", {v[30:0], e}, 1);
    apb(1'b1, msp_pkg::OFS_CTRL, 32'h0, v, e);
    msp_host_i.begin_shift(1'b0);
    check("oe_off", devOe, 0);
    msp_host_i.end_shift();
    apb(1'b1, msp_pkg::OFS_CTRL, 32'h1, v, e);
    check("ctrl_err", e, 0);
    msp_host_i.step(RCYC);
    check("ready", digitalReady, 1);
    $display("test apb done");
    msp_host_i.write_cmd(8'hAF);
    msp_host_i.write_cmd(8'hF0);
    msp_host_i.write_cmd(8'h80);
    check("cfg_lo", cfgBits[31:0], 32'h1);
    check("cfg_hi", cfgBits[63:32], 32'h0000_8000);
    check("mode", modeBits, 15'h0001);
    apb(1'b0, msp_pkg::OFS_CFG0 + 8'h04, 32'h0, v, e);
    check("cfg_word1", v, 32'h0000_8000);
    $display("test write done");
    msp_host_i.begin_shift(1'b1);
    check("latch", latches, 1);
    check("oe", devOe, 1);
    for (int k = 0; k <= NREC; k++) begin
      msp_host_i.read_rec(1'b0, v);
      check("rec", v, k < NREC ? rec(k) : 32'hFFFF_FFFF);
    end
    msp_host_i.end_shift();
    $display("test read done");
    recordsIn <= '0;
    for (int k = 0; k < 2; k++) begin
      msp_host_i.begin_shift(1'b0);
      msp_host_i.read_rec(1'b0, v);
      check("reread", v, rec(0));
      msp_host_i.end_shift();
    end
    msp_host_i.write_cmd(8'hE4);
    msp_host_i.begin_shift(1'b0);
    msp_host_i.read_rec(1'b1, v);
    check("lsb_first", v, rec(0));
    msp_host_i.end_shift();
    $display("test abort done");
    for (int i = 0; i < NREC; i++) recordsIn[32*i+:32] <= rec(i);
    msp_host_i.write_cmd(8'hFF);
    check("group", groupPtr, 1);
    apb(1'b0, msp_pkg::OFS_STATUS, 32'h0, v, e);
    check("st_group", v[2:0], 1);
    msp_host_i.begin_shift(1'b1);
    msp_host_i.read_rec(1'b1, v);
    check("next_group", v, rec(1));
    msp_host_i.end_shift();
    $display("test precharge done");
    msp_host_i.precharge_plain();
    check("plain_group", groupPtr, 2);
    msp_host_i.begin_shift(1'b0);
    msp_host_i.read_rec(1'b1, v);
    check("plain_rec", v, rec(2));
    msp_host_i.end_shift();
    $display("test plain precharge done");
    msp_host_i.remote_reset();
    check("rr_pulse", resets, 1);
    check("rr_ready", digitalReady, 1);
    check("rr_mode", modeBits, 15'h0001);
    check("rr_cfg", cfgBits[31:0], 32'h0);
    check("clash", clash, 0);
    $display("test remote reset done");
    print_verdict();
  end
endmodule
